// ===== fcc_pkg.sv
// Purpose: Shared constants for the flash command controller.
// Assumes: 20 MHz clock, 16-bit flash data bus, 20-bit flash address.
// Notes:   Operation codes are written by software into the control register.
`default_nettype none
package fcc_pkg;
	// Flash bus shape
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int WB_AW  = 5;
	// Command data values
	localparam logic [15:0] CMD_UNLOCK1 = 16'h00aa;
	localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
	localparam logic [15:0] CMD_SETUP   = 16'h0080;
	localparam logic [15:0] CMD_CHIP    = 16'h0010;
	localparam logic [15:0] CMD_SECTOR  = 16'h0030;
	localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
	localparam logic [15:0] CMD_RESUME  = 16'h0030;
	localparam logic [15:0] CMD_PROG    = 16'h00a0;
	localparam logic [15:0] CMD_IDENT   = 16'h0090;
	localparam logic [15:0] CMD_RESET   = 16'h00f0;
	// Unlock addresses
	localparam logic [ADDR_W-1:0] ADR_UNLOCK1 = 20'h00555;
	localparam logic [ADDR_W-1:0] ADR_UNLOCK2 = 20'h002aa;
	localparam logic [ADDR_W-1:0] ADR_ZERO    = 20'h00000;
	// Operation codes in the control register
	localparam logic [3:0] OP_READ    = 4'h0;
	localparam logic [3:0] OP_RESET   = 4'h1;
	localparam logic [3:0] OP_PROG    = 4'h2;
	localparam logic [3:0] OP_CHIP    = 4'h3;
	localparam logic [3:0] OP_SECT    = 4'h4;
	localparam logic [3:0] OP_ADDSECT = 4'h5;
	localparam logic [3:0] OP_SUSP    = 4'h6;
	localparam logic [3:0] OP_RESUME  = 4'h7;
	localparam logic [3:0] OP_IDENT   = 4'h8;
	// Register byte offsets
	localparam logic [WB_AW-1:0] REG_CTRL   = 5'h00;
	localparam logic [WB_AW-1:0] REG_ADDR   = 5'h04;
	localparam logic [WB_AW-1:0] REG_WDATA  = 5'h08;
	localparam logic [WB_AW-1:0] REG_STATUS = 5'h0c;
	localparam logic [WB_AW-1:0] REG_RDATA  = 5'h10;
	// Polled status bit positions
	localparam int TOGGLE_BIT  = 6;
	localparam int TIMEOUT_BIT = 5;
	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int CLK_MHZ       = 20;
	localparam int T_ACC_NS      = 100;
	localparam int ACC_CYC       = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_CYC      = 2;
	localparam int T_WIN_US      = 50;
	localparam int WIN_CYC       = T_WIN_US * CLK_MHZ;
	localparam int T_SUSP_US     = 20;
	localparam int SUSP_CYC      = T_SUSP_US * CLK_MHZ;
	localparam int T_GAP_US      = 400;
	localparam int GAP_CYC       = T_GAP_US * CLK_MHZ;
endpackage
`default_nettype wire

// ===== fcc_bus_cycle.sv
// Purpose: One asynchronous flash read or write cycle on the pins.
// Assumes: Start only while idle; data pins sampled through two flops.
// Notes:   All pin outputs are registered, so no glitches on strobes.
`timescale 1ns/10ps
`default_nettype none
module fcc_bus_cycle (
	input  wire logic                       clk_in,
	input  wire logic                       reset_in,
	input  wire logic                       start_in,
	input  wire logic                       write_in,
	input  wire logic [fcc_pkg::ADDR_W-1:0] addr_in,
	input  wire logic [fcc_pkg::DATA_W-1:0] data_in,
	output logic                            done_out,
	output logic      [fcc_pkg::DATA_W-1:0] rdata_out,
	output logic      [fcc_pkg::ADDR_W-1:0] f_addr_out,
	input  wire logic [fcc_pkg::DATA_W-1:0] f_dq_in,
	output logic      [fcc_pkg::DATA_W-1:0] f_dq_out,
	output logic                            f_dq_oe_out,
	output logic                            f_ce_n_out,
	output logic                            f_oe_n_out,
	output logic                            f_we_n_out
);
	import fcc_pkg::*;
	typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_HOLD} fcc_bc_e;
	fcc_bc_e             state, next_state;   // Cycle phase
	logic [3:0]          cnt, next_cnt;       // Phase length counter
	logic                wr, next_wr;         // Cycle is a write
	logic [DATA_W-1:0]   dq_s1, dq_s2;        // Data pin synchroniser
	logic [DATA_W-1:0]   next_rdata;
	logic [ADDR_W-1:0]   next_addr;
	logic [DATA_W-1:0]   next_dq;
	logic                next_oe, next_ce_n, next_oen, next_wen, next_done;

	// Two-flop synchroniser on data pins
	always_ff @(posedge clk_in) begin
		dq_s1 <= f_dq_in;
		dq_s2 <= dq_s1;
	end

	// Phase sequencing and pin values
	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		next_wr    = wr;
		next_rdata = rdata_out;
		next_addr  = f_addr_out;
		next_dq    = f_dq_out;
		next_oe    = f_dq_oe_out;
		next_ce_n  = f_ce_n_out;
		next_oen   = f_oe_n_out;
		next_wen   = f_we_n_out;
		next_done  = 1'b0;
		case (state)
			BC_IDLE: begin
				if (start_in) begin
					// Address and data settle before any strobe falls
					next_wr    = write_in;
					next_addr  = addr_in;
					next_dq    = data_in;
					next_oe    = write_in;
					next_ce_n  = 1'b0;
					next_state = BC_SETUP;
				end
			end
			BC_SETUP: begin
				next_wen   = ~wr;
				next_oen   = wr;
				// Reads wait extra cycles for the synchroniser
				next_cnt   = wr ? 4'(ACC_CYC) : 4'(ACC_CYC + SYNC_CYC);
				next_state = BC_STROBE;
			end
			BC_STROBE: begin
				if (cnt > 4'h1) begin
					next_cnt = cnt - 4'h1;
				end else begin
					next_wen   = 1'b1;
					next_state = BC_HOLD;
					if (!wr) begin
						next_rdata = dq_s2;
						next_oen   = 1'b1;
					end
				end
			end
			BC_HOLD: begin
				// Strobe rose last cycle; chip select now follows
				next_ce_n  = 1'b1;
				next_oe    = 1'b0;
				next_done  = 1'b1;
				next_state = BC_IDLE;
			end
			default: next_state = BC_IDLE;
		endcase
	end

	// Phase registers
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state       <= BC_IDLE;
			cnt         <= 4'h0;
			wr          <= 1'b0;
			rdata_out   <= 16'h0000;
			f_addr_out  <= 20'h00000;
			f_dq_out    <= 16'h0000;
			f_dq_oe_out <= 1'b0;
			f_ce_n_out  <= 1'b1;
			f_oe_n_out  <= 1'b1;
			f_we_n_out  <= 1'b1;
			done_out    <= 1'b0;
		end else begin
			state       <= next_state;
			cnt         <= next_cnt;
			wr          <= next_wr;
			rdata_out   <= next_rdata;
			f_addr_out  <= next_addr;
			f_dq_out    <= next_dq;
			f_dq_oe_out <= next_oe;
			f_ce_n_out  <= next_ce_n;
			f_oe_n_out  <= next_oen;
			f_we_n_out  <= next_wen;
			done_out    <= next_done;
		end
	end
endmodule
`default_nettype wire

// ===== fcc_ctrl.sv
// Purpose: Host-side controller issuing flash command sequences.
// Assumes: Software drives it over classic Wishbone; flash is asynchronous.
// Notes:   Completion found by toggle-bit polling at the operation address.
// Behaviour
// R1: Chip erase: unlock, unlock, 80H, unlock, unlock, 10H.
// R2: Sector erase ends with 30H at sector address.
// R3: Device pre-programs zeros before erasing.
// R4: Erase done when toggle bit stops changing.
// R5: Device raises timeout flag on failed erase.
// R6: Erase starts at final strobe rising edge.
// R7: Device returns to array read by itself.
// R8: Suspended sectors read back status data.
// R9: Host writes reset after timeout or identification.
// R10: Reset aborts erase only between sequence cycles.
// R11: Reset aborts program only between cycles.
// R12: Identification mode held until reset written.
// R13: Address latched late, data early strobe edge.
// R14: Next sector load within 50us window.
// R15: Other commands in window abandon erase.
// R16: Suspend only during sector erase, 20us.
// R17: Suspended device accepts resume, program, read.
// R18: Resume acts only after a suspend.
// R19: At least 400us from resume to suspend.
// R20: Program: unlock, unlock, setup, address and data.
// R21: Device ignores commands while programming.
// R22: Programming cannot turn 0 into 1.
// R23: Reset command data is F0H.
// R24: Identification reads give maker and device codes.
// R25: Protection verify reads 01H or 00H.
// R26: Wrong value or order returns to read.
// R27: Ready-busy low while algorithm runs.
`timescale 1ns/10ps
`default_nettype none
module fcc_ctrl #(
	parameter int GAP_CYCLES = fcc_pkg::GAP_CYC
) (
	input  wire logic                       clk_in,
	input  wire logic                       reset_in,
	input  wire logic                       wb_cyc_in,
	input  wire logic                       wb_stb_in,
	input  wire logic                       wb_we_in,
	input  wire logic [fcc_pkg::WB_AW-1:0]  wb_adr_in,
	input  wire logic [3:0]                 wb_sel_in,
	input  wire logic [31:0]                wb_dat_in,
	output logic      [31:0]                wb_dat_out,
	output logic                            wb_ack_out,
	output logic      [fcc_pkg::ADDR_W-1:0] flash_addr_out,
	input  wire logic [fcc_pkg::DATA_W-1:0] flash_dq_in,
	output logic      [fcc_pkg::DATA_W-1:0] flash_dq_out,
	output logic                            flash_dq_oe_out,
	output logic                            flash_ce_n_out,
	output logic                            flash_oe_n_out,
	output logic                            flash_we_n_out,
	input  wire logic                       ready_busy_n_in
);
	import fcc_pkg::*;
	typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_WAIT_W, ST_POLL_RD,
		ST_POLL_WT, ST_READ_WT, ST_SUSP_WT} fcc_st_e;
	fcc_st_e           state, next_state;     // Sequencer state
	logic [3:0]        op, next_op;           // Operation in progress
	logic [2:0]        step, next_step;       // Write cycle index
	logic [ADDR_W-1:0] addr_r, next_addr_r;   // Operation address
	logic [DATA_W-1:0] wdata, next_wdata;     // Program data
	logic [DATA_W-1:0] rdata, next_rdata;     // Last read result
	logic [9:0]        win_cnt, next_win_cnt; // Sector load window
	logic [8:0]        susp_cnt, next_susp;   // Suspend settle time
	logic [13:0]       gap_cnt, next_gap;     // Resume to suspend gap
	logic              win_open, next_win_open;
	logic              erasing, next_erasing; // Sector erase under way
	logic              suspended, next_susp_f;
	logic              id_mode, next_id_mode;
	logic              fail, next_fail;
	logic              refused, next_refused;
	logic              p_have, next_p_have;   // First poll read taken
	logic              p_prev, next_p_prev;   // Previous toggle value
	logic              p_late, next_p_late;   // Timeout flag already seen
	logic              rb_s1, rb_s2;          // Ready-busy synchroniser
	logic              go;                    // Control register written
	logic              bus_start, bus_write, bus_done;
	logic [ADDR_W-1:0] bus_addr;
	logic [DATA_W-1:0] bus_data, bus_rdata;
	logic [ADDR_W+DATA_W-1:0] seq_word;
	logic [31:0]       wmask, status;
	logic              wb_hit;

	// Address and data of each command write
	function automatic logic [ADDR_W+DATA_W-1:0] seq_of(input logic [3:0] o,
		input logic [2:0] s, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [ADDR_W+DATA_W-1:0] r;
		r = {ADR_ZERO, CMD_RESET};                              // [R23]
		case (o)
			OP_PROG, OP_CHIP, OP_SECT, OP_IDENT: begin
				// Unlock pair opens every long sequence [R26]
				if (s == 3'h0 || s == 3'h3) r = {ADR_UNLOCK1, CMD_UNLOCK1};
				else if (s == 3'h1 || s == 3'h4) r = {ADR_UNLOCK2, CMD_UNLOCK2};
				else if (o == OP_PROG && s == 3'h2) r = {ADR_UNLOCK1, CMD_PROG};
				else if (o == OP_IDENT) r = {ADR_UNLOCK1, CMD_IDENT};
				else if (s == 3'h2) r = {ADR_UNLOCK1, CMD_SETUP};   // [R1]
				else if (o == OP_CHIP) r = {ADR_UNLOCK1, CMD_CHIP}; // [R1]
				else r = {a, CMD_SECTOR};                           // [R2]
				if (o == OP_PROG && s == 3'h3) r = {a, d};          // [R20]
			end
			OP_ADDSECT: r = {a, CMD_SECTOR};                        // [R14]
			OP_SUSP:    r = {ADR_ZERO, CMD_SUSPEND};
			OP_RESUME:  r = {ADR_ZERO, CMD_RESUME};
			default:    r = {ADR_ZERO, CMD_RESET};
		endcase
		return r;
	endfunction

	// Number of write cycles per operation
	function automatic logic [2:0] len_of(input logic [3:0] o);
		case (o)
			OP_PROG:         return 3'h4;                           // [R20]
			OP_CHIP, OP_SECT: return 3'h6;                          // [R1] [R2]
			OP_IDENT:        return 3'h3;
			default:         return 3'h1;
		endcase
	endfunction

	fcc_bus_cycle u_cycle (
		.clk_in      (clk_in),
		.reset_in    (reset_in),
		.start_in    (bus_start),
		.write_in    (bus_write),
		.addr_in     (bus_addr),
		.data_in     (bus_data),
		.done_out    (bus_done),
		.rdata_out   (bus_rdata),
		.f_addr_out  (flash_addr_out),
		.f_dq_in     (flash_dq_in),
		.f_dq_out    (flash_dq_out),
		.f_dq_oe_out (flash_dq_oe_out),
		.f_ce_n_out  (flash_ce_n_out),
		.f_oe_n_out  (flash_oe_n_out),
		.f_we_n_out  (flash_we_n_out)
	);

	// Ready-busy pin is asynchronous; status use only
	always_ff @(posedge clk_in) begin
		rb_s1 <= ready_busy_n_in;
		rb_s2 <= rb_s1;
	end

	// Bus slave decode; writes land on the edge that sees ack
	assign wb_hit = wb_cyc_in && wb_stb_in && wb_ack_out;
	assign go     = wb_hit && wb_we_in && wb_adr_in == REG_CTRL && wb_sel_in[0];
	assign wmask  = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}},
		{8{wb_sel_in[0]}}};
	assign status = {24'h000000, erasing, rb_s2, refused, fail, id_mode,
		suspended, win_open, state != ST_IDLE};
	assign seq_word = seq_of(op, step, addr_r, wdata);

	// Sequencer next state
	always_comb begin
		next_state = state;   next_op = op;         next_step = step;
		next_addr_r = addr_r; next_wdata = wdata;   next_rdata = rdata;
		next_win_cnt = win_cnt; next_susp = susp_cnt;
		next_gap = (gap_cnt != 14'h0000) ? gap_cnt - 14'h0001 : gap_cnt;
		next_win_open = win_open; next_erasing = erasing;
		next_susp_f = suspended; next_id_mode = id_mode;
		next_fail = fail;     next_refused = refused;
		next_p_have = p_have; next_p_prev = p_prev; next_p_late = p_late;
		bus_start = 1'b0;     bus_write = 1'b0;
		bus_addr = addr_r;    bus_data = wdata;
		if (wb_hit && wb_we_in && wb_adr_in == REG_ADDR)
			next_addr_r = ADDR_W'(({12'h000, addr_r} & ~wmask) | (wb_dat_in & wmask));
		if (wb_hit && wb_we_in && wb_adr_in == REG_WDATA)
			next_wdata = DATA_W'(({16'h0000, wdata} & ~wmask) | (wb_dat_in & wmask));
		// Orders outside idle are refused, bar suspend in ST_POLL_RD
		if (go && state != ST_IDLE && !(state == ST_POLL_RD && wb_dat_in[3:0] == OP_SUSP))
			next_refused = 1'b1;
		case (state)
			ST_IDLE: begin
				if (go) begin
					next_op = wb_dat_in[3:0];
					next_step = 3'h0;
					next_refused = 1'b0;
					next_fail = 1'b0;
					next_state = ST_ISSUE;
					case (wb_dat_in[3:0])
						OP_READ: if (win_open) next_refused = 1'b1; // [R15]
							else next_state = ST_READ_WT;
						OP_ADDSECT: if (!win_open) next_refused = 1'b1; // [R14]
						OP_SUSP: if (!win_open || gap_cnt != 14'h0000)  // [R19]
							next_refused = 1'b1;
						OP_RESUME: if (!suspended) next_refused = 1'b1;
						OP_CHIP, OP_SECT: if (suspended || id_mode || win_open)
							next_refused = 1'b1;
						OP_PROG: if (id_mode || win_open) next_refused = 1'b1;
						OP_RESET, OP_IDENT: if (win_open) next_refused = 1'b1;
						default: next_refused = 1'b1;
					endcase
					if (next_refused) next_state = ST_IDLE;
					if (wb_dat_in[3:0] == OP_READ && !win_open) begin
						bus_start = 1'b1;
						bus_addr = addr_r;
					end
				end else if (win_open) begin
					// Window expiry hands over to erase polling [R14]
					if (win_cnt > 10'h001) begin
						next_win_cnt = win_cnt - 10'h001;
					end else begin
						next_win_open = 1'b0;
						next_erasing = 1'b1;
						next_op = OP_SECT;
						next_p_have = 1'b0;
						next_p_late = 1'b0;
						next_state = ST_POLL_RD;
					end
				end
			end
			ST_ISSUE: begin
				bus_start = 1'b1;
				bus_write = 1'b1;
				bus_addr = seq_word[ADDR_W+DATA_W-1:DATA_W];
				bus_data = seq_word[DATA_W-1:0];
				next_state = ST_WAIT_W;
			end
			ST_WAIT_W: begin
				if (bus_done) begin
					next_state = ST_IDLE;
					next_p_have = 1'b0;
					next_p_late = 1'b0;
					if (step + 3'h1 < len_of(op)) begin
						next_step = step + 3'h1;
						next_state = ST_ISSUE;
					end else begin
						case (op)
							OP_PROG, OP_CHIP: next_state = ST_POLL_RD; // [R4]
							OP_SECT, OP_ADDSECT: begin
								next_win_open = 1'b1;
								next_win_cnt = 10'(WIN_CYC);
							end
							OP_SUSP: begin
								next_win_open = 1'b0;
								next_susp = 9'(SUSP_CYC);
								next_state = ST_SUSP_WT;
							end
							OP_RESUME: begin
								next_susp_f = 1'b0;
								// Sector erase runs again, so a later suspend is legal
								next_erasing = 1'b1;
								next_gap = 14'(GAP_CYCLES);            // [R19]
								next_op = OP_SECT;
								next_state = ST_POLL_RD;
							end
							OP_IDENT: next_id_mode = 1'b1;
							OP_RESET: next_id_mode = 1'b0;                 // [R9]
							default: next_state = ST_IDLE;
						endcase
					end
				end
			end
			ST_POLL_RD: begin
				if (go && wb_dat_in[3:0] == OP_SUSP && erasing && !suspended) begin
					next_refused = gap_cnt != 14'h0000;
					if (gap_cnt == 14'h0000) begin
						next_op = OP_SUSP;
						next_step = 3'h0;
						next_state = ST_ISSUE;
					end
				end else begin
					// Suspend with no running sector erase is refused
					if (go) next_refused = 1'b1;
					bus_start = 1'b1;
					next_state = ST_POLL_WT;
				end
			end
			ST_POLL_WT: begin
				if (bus_done) begin
					next_rdata = bus_rdata;
					next_state = ST_POLL_RD;
					next_p_have = 1'b1;
					next_p_prev = bus_rdata[TOGGLE_BIT];
					if (p_have && bus_rdata[TOGGLE_BIT] == p_prev) begin
						// Toggle stopped: operation finished [R4]
						next_state = ST_IDLE;
						if (op != OP_PROG) next_erasing = 1'b0;
					end else if (p_have && p_late) begin
						// Still toggling after timeout flag: reset [R9]
						next_fail = 1'b1;
						next_erasing = 1'b0;
						next_op = OP_RESET;
						next_step = 3'h0;
						next_state = ST_ISSUE;
					end else if (p_have) begin
						next_p_late = bus_rdata[TIMEOUT_BIT];
					end
				end
			end
			ST_READ_WT: begin
				if (bus_done) begin
					next_rdata = bus_rdata;
					next_state = ST_IDLE;
				end
			end
			ST_SUSP_WT: begin
				// Give the device its full suspend latency
				if (susp_cnt > 9'h001) begin
					next_susp = susp_cnt - 9'h001;
				end else begin
					next_susp_f = 1'b1;
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// Sequencer and bus slave registers
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state <= ST_IDLE;  op <= OP_READ;  step <= 3'h0;
			addr_r <= 20'h00000; wdata <= 16'h0000; rdata <= 16'h0000;
			win_cnt <= 10'h000; susp_cnt <= 9'h000; gap_cnt <= 14'h0000;
			win_open <= 1'b0; erasing <= 1'b0; suspended <= 1'b0;
			id_mode <= 1'b0; fail <= 1'b0; refused <= 1'b0;
			p_have <= 1'b0; p_prev <= 1'b0; p_late <= 1'b0;
			wb_ack_out <= 1'b0; wb_dat_out <= 32'h00000000;
		end else begin
			state <= next_state; op <= next_op; step <= next_step;
			addr_r <= next_addr_r; wdata <= next_wdata; rdata <= next_rdata;
			win_cnt <= next_win_cnt; susp_cnt <= next_susp; gap_cnt <= next_gap;
			win_open <= next_win_open; erasing <= next_erasing;
			suspended <= next_susp_f; id_mode <= next_id_mode;
			fail <= next_fail; refused <= next_refused;
			p_have <= next_p_have; p_prev <= next_p_prev; p_late <= next_p_late;
			// Ack one cycle after request; unmapped reads give zero
			wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
			case (wb_adr_in)
				REG_CTRL:   wb_dat_out <= {28'h0000000, op};
				REG_ADDR:   wb_dat_out <= {12'h000, addr_r};
				REG_WDATA:  wb_dat_out <= {16'h0000, wdata};
				REG_STATUS: wb_dat_out <= status;
				REG_RDATA:  wb_dat_out <= {16'h0000, rdata};
				default:    wb_dat_out <= 32'h00000000;
			endcase
		end
	end

	// Checks on the issued command stream
	chip_code_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R1]
		state == ST_ISSUE && op == OP_CHIP && step == 3'h5 |-> bus_data == CMD_CHIP)
		else $error("chip erase final code wrong");
	erase_setup_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R1]
		state == ST_ISSUE && (op == OP_CHIP || op == OP_SECT) && step == 3'h2
		|-> bus_data == CMD_SETUP && bus_addr == ADR_UNLOCK1)
		else $error("erase setup write wrong");
	sect_code_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R2]
		state == ST_ISSUE && op == OP_SECT && step == 3'h5
		|-> bus_data == CMD_SECTOR && bus_addr == addr_r)
		else $error("sector erase write wrong");
	unlock_first_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R26]
		state == ST_ISSUE && op == OP_PROG && step == 3'h0
		|-> bus_addr == ADR_UNLOCK1 ##1 state == ST_WAIT_W)
		else $error("unlock write wrong");
	prog_poll_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R20]
		state == ST_WAIT_W && op == OP_PROG && step == 3'h3 && bus_done
		|=> state == ST_POLL_RD ##1 state == ST_POLL_WT)
		else $error("program did not start polling");
	window_load_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R14]
		state == ST_ISSUE && op == OP_ADDSECT |-> win_open && win_cnt <= 10'(WIN_CYC))
		else $error("sector load outside window");
	resume_gap_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R19]
		state == ST_ISSUE && op == OP_SUSP |-> gap_cnt == 14'h0000)
		else $error("suspend too soon after resume");
	fail_reset_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R9]
		$rose(fail) |-> op == OP_RESET && state == ST_ISSUE && bus_data == CMD_RESET
		##1 state == ST_WAIT_W)
		else $error("no reset after failure");
	reset_code_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R23]
		state == ST_ISSUE && op == OP_RESET |-> bus_data == CMD_RESET)
		else $error("reset code wrong");
endmodule
`default_nettype wire

// ===== fcc_flash_model.sv
// Purpose: Behavioural flash device facing the controller.
// Assumes: Commands taken at the write strobe rise; sectors are 4K words.
// Notes:   Busy time shortened; identification values are arbitrary.
`timescale 1ns/10ps
`default_nettype none
module fcc_flash_model #(
	parameter logic [15:0] MAKER   = 16'h0a01, // Arbitrary value
	parameter logic [15:0] DEVICE  = 16'h0b02, // Arbitrary value
	parameter int          BUSY_NS = 20000
) (
	input  wire logic [19:0] addr_in,
	input  wire logic [15:0] dq_in,
	output logic      [15:0] dq_out,
	input  wire logic        ce_n_in,
	input  wire logic        oe_n_in,
	input  wire logic        we_n_in,
	input  wire logic        dq_oe_in,
	output logic             ready_busy_n_out
);
	logic [15:0] mem [logic [19:0]]; // Unwritten words read erased
	logic [3:0]  step;               // Place in a command sequence
	logic        busy;               // Algorithm running
	logic        tog;                // Toggle bit state
	logic        idm;                // Identification mode
	logic [15:0] rd;                 // Word the pins would show
	initial begin
		step = 4'h0;
		busy = 1'b0;
		tog = 1'b0;
		idm = 1'b0;
		ready_busy_n_out = 1'b1;
	end
	// Read source: id codes, toggling status while busy, else array
	// Timeout flag stays low: every erase here finishes in time
	always @* begin
		if (idm) rd = addr_in[0] ? DEVICE : MAKER;
		else if (busy) rd = {9'h0, tog, 6'h0};
		else rd = mem.exists(addr_in) ? mem[addr_in] : 16'hffff;
	end
	// Unselected pins show the inverse, so a stale word never passes
	assign dq_out = (!ce_n_in && !oe_n_in) ? rd : ~rd;
	always @(posedge oe_n_in) if (busy) tog <= ~tog;
	// Blocking delay below also drops writes while busy
	always @(posedge we_n_in) if (!ce_n_in && dq_oe_in && !busy) begin
		if (dq_in[7:0] == 8'hf0) begin
			step = 4'h0;
			idm = 1'b0;
		end else case (step)
			0, 3: step = (dq_in[7:0] == 8'haa) ? step + 4'h1 : 4'h0;
			1, 4: step = (dq_in[7:0] == 8'h55) ? step + 4'h1 : 4'h0;
			2: begin
				idm = dq_in[7:0] == 8'h90;
				step = (dq_in[7:0] == 8'h80) ? 4'h3 : (dq_in[7:0] == 8'ha0) ? 4'h8 : 4'h0;
			end
			default: begin
				if (step == 4'h8) mem[addr_in] = rd & dq_in;
				else foreach (mem[k])
					if (dq_in[7:0] == 8'h10 || k[19:12] == addr_in[19:12])
						mem[k] = 16'hffff;
				step = 4'h0;
				busy = 1'b1;
				ready_busy_n_out = 1'b0;
				#BUSY_NS busy = 1'b0;
				ready_busy_n_out = 1'b1;
			end
		endcase
	end
endmodule
`default_nettype wire

// ===== fcc_ctrl_tb.sv
// Purpose: Self-checking bench for the flash command controller.
// Assumes: Flash model answers with a shortened busy time.
// Notes:   Random addresses and data from a fixed xorshift seed.
`timescale 1ns/10ps
`default_nettype none
module fcc_ctrl_tb;
	import fcc_pkg::*;
	localparam logic [15:0] MAKER = 16'h0a01, DEVICE = 16'h0b02; // Arbitrary
	logic        clk_in = 0, reset_in = 1, cyc = 0, stb = 0, we = 0, ack;
	logic        ce_n, oe_n, we_n, rb_n, dq_oe;
	logic [4:0]  adr = '0;
	logic [31:0] dat = '0, rdat, q, r, seed = 37839;
	logic [19:0] fa, pa;
	logic [15:0] fd, dq_o, dq_i;
	int          miscompares = 0, n_tests = 0, cycles = 0;
	always #25 clk_in = ~clk_in;
	fcc_ctrl #(.GAP_CYCLES(20)) uut (.clk_in(clk_in), .reset_in(reset_in),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
		.wb_sel_in(4'hf), .wb_dat_in(dat), .wb_dat_out(rdat), .wb_ack_out(ack),
		.flash_addr_out(pa), .flash_dq_in(dq_i), .flash_dq_out(dq_o),
		.flash_dq_oe_out(dq_oe), .flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n),
		.flash_we_n_out(we_n), .ready_busy_n_in(rb_n));
	fcc_flash_model #(.MAKER(MAKER), .DEVICE(DEVICE)) m (.addr_in(pa), .dq_in(dq_o),
		.dq_out(dq_i), .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n), .dq_oe_in(dq_oe),
		.ready_busy_n_out(rb_n));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Expected identification word for a given low address bit
	function automatic logic [31:0] id_exp(input logic a0);
		return {16'h0, a0 ? DEVICE : MAKER};
	endfunction
	// Classic cycle: hold until ack is sampled, then one idle cycle
	task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		@(posedge clk_in);
		while (ack !== 1'b1) @(posedge clk_in);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_in);
	endtask
	// Issue an order and poll until the busy bit clears
	task automatic op(input logic [3:0] o, input logic [19:0] a, input logic [15:0] d);
		wb(1'b1, REG_ADDR, {12'h0, a});
		wb(1'b1, REG_WDATA, {16'h0, d});
		wb(1'b1, REG_CTRL, {28'h0, o});
		q = 32'h1;
		// An open sector window also counts as unfinished
		while (q[1:0] !== 2'b00) wb(1'b0, REG_STATUS, '0);
	endtask
	task automatic rd_at(input logic [19:0] a);
		op(OP_READ, a, '0);
		wb(1'b0, REG_RDATA, '0);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Hang guard counts cycles from time zero, sized well above the whole test run
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (16) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		wb(1'b0, REG_STATUS, '0);
		chk(q & 32'hff, 32'h40);
		wb(1'b0, 5'h14, '0);
		chk(q, '0);
		wb(1'b1, REG_CTRL, {28'h0, OP_SUSP});
		wb(1'b0, REG_STATUS, '0);
		chk(q[5:0], 6'h20);
		wb(1'b1, REG_CTRL, {28'h0, OP_RESUME});
		wb(1'b0, REG_STATUS, '0);
		chk(q[5:0], 6'h20);
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			r = xs();
			fa = {8'h01, r[11:0]};
			fd = r[31:16];
			op(OP_PROG, fa, fd);
			rd_at(fa);
			chk(q, {16'h0, fd});
		end
		op(OP_PROG, fa, 16'hffff);
		rd_at(fa);
		chk(q, {16'h0, fd});
		wb(1'b1, REG_ADDR, {12'h0, fa});
		wb(1'b1, REG_CTRL, {28'h0, OP_SECT});
		q = '0;
		while (q[1] !== 1'b1) wb(1'b0, REG_STATUS, '0);
		wb(1'b1, REG_CTRL, {28'h0, OP_PROG});
		wb(1'b0, REG_STATUS, '0);
		chk(q[5:0], 6'h22);
		while (q[1:0] !== 2'b00) wb(1'b0, REG_STATUS, '0);
		rd_at(fa);
		chk(q, 32'hffff);
		$display("program and sector erase done");
		op(OP_IDENT, '0, '0);
		for (int i = 0; i < 2; i++) begin
			rd_at(20'(i));
			chk(q, id_exp(i[0]));
		end
		op(OP_RESET, '0, '0);
		rd_at(fa);
		chk(q, 32'hffff);
		$display("identification done");
		op(OP_PROG, '0, fd);
		wb(1'b1, REG_ADDR, '0);
		wb(1'b1, REG_CTRL, {28'h0, OP_CHIP});
		wb(1'b1, REG_CTRL, {28'h0, OP_READ});
		wb(1'b0, REG_STATUS, '0);
		chk(q[5], 1'b1);
		while (q[0] !== 1'b0) wb(1'b0, REG_STATUS, '0);
		rd_at('0);
		chk(q, 32'hffff);
		$display("chip erase done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
